/* File: bench/emb_ext_bus_tb.sv */
/*
 * emb_ext_bus_tb: self-checking bench of the external bus interface.
 * Assumes the memory model on the pins; the core side, register port
 * and enable bits are driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module emb_ext_bus_tb;
   // ************************************************************
   // signals
   // ************************************************************
   typedef struct {logic [7:0] ctrl; logic [3:0] f; logic [15:0] adr; logic [7:0] d;
      logic [3:0] lag;} emb_row_t;
   logic clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ext_en = 1'b0;
   logic gen_en = 1'b0, code_ram = 1'b0, req = 1'b0, req_we = 1'b0, req_ri = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, req_ri_low = 8'h00, req_wdata = 8'h00;
   logic [15:0] req_addr = 16'h0000, fetch_addr = 16'h1000;
   logic [7:0] sfr_rdata, rdata, fetch_data, p0_in, p0_out, p2_out, p6_out;
   logic req_ready, ack, fetch_from_ram, p0_oe, rd_n, wr_n, ale;
   logic nonmux = 1'b0, busy = 1'b0, bad = 1'b0;
   logic [3:0] lag = 4'h0;
   logic [7:0] p2s, p6s, alo, v;
   int errors = 0, num_checks = 0, strb = 0, alen = 0;
   // (ctrl, en gen we ri, address, data, model lag): writes then reads back
   emb_row_t rows [20] = '{
      '{8'h00,4'hA,16'h8123,8'hA5,4'h0}, '{8'h02,4'h8,16'h8123,8'hA5,4'h0},
      '{8'h83,4'hA,16'hC0FF,8'h3C,4'h0}, '{8'h83,4'h8,16'hC0FF,8'h3C,4'h0},
      '{8'hC2,4'hE,16'h8010,8'h11,4'h0}, '{8'hC2,4'hE,16'h9010,8'h22,4'h0},
      '{8'hC2,4'hE,16'hA010,8'h33,4'h0}, '{8'hC2,4'hE,16'hB010,8'h44,4'h0},
      '{8'hC2,4'hC,16'hC010,8'h11,4'h0}, '{8'hC2,4'hC,16'hF010,8'h44,4'h0},
      '{8'hC2,4'hC,16'hD010,8'h22,4'h0}, '{8'hC2,4'hA,16'h9010,8'h77,4'h0},
      '{8'hC2,4'h8,16'h9010,8'h77,4'h0}, '{8'h82,4'hB,16'h9034,8'h5E,4'h0},
      '{8'h82,4'h8,16'h9034,8'h5E,4'h0}, '{8'h82,4'hA,16'h0123,8'hC3,4'h0},
      '{8'h82,4'h8,16'h0123,8'hC3,4'h0}, '{8'h82,4'h8,16'h4000,8'h00,4'h0},
      '{8'h82,4'h0,16'h8123,8'h00,4'h0}, '{8'h8F,4'h8,16'hC0FF,8'h3C,4'hC}};
   // ************************************************************
   // design, far-side model, clock
   // ************************************************************
   emb_ext_bus u_emb_ext_bus (.clk(clk), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .external_bus_enable_bit(ext_en), .bus_general_enable_bit(gen_en),
      .code_from_ram_bit(code_ram), .req(req), .req_we(req_we), .req_ri(req_ri),
      .req_addr(req_addr), .req_ri_low(req_ri_low), .req_wdata(req_wdata),
      .req_ready(req_ready), .ack(ack), .rdata(rdata), .fetch_addr(fetch_addr),
      .fetch_from_ram(fetch_from_ram), .fetch_data(fetch_data), .p0_in(p0_in),
      .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p6_out(p6_out), .rd_n(rd_n),
      .wr_n(wr_n), .ale(ale));
   emb_mem_model u_emb_mem_model (.clk(clk), .p0_out(p0_out), .p0_oe(p0_oe),
      .p2_out(p2_out), .p6_out(p6_out), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
      .p0_in(p0_in), .nonmux(nonmux), .resp_lag(lag));
   always #2 clk = ~clk;
   // pin watcher: strobe length, latch pulses, lines held through the strobe
   always @(posedge clk) if (busy) begin
      if (!rd_n || !wr_n) begin
         if (strb != 0 && (p2_out !== p2s || p6_out !== p6s)) bad <= 1'b1;
         if (!rd_n && p0_oe) bad <= 1'b1;
         p2s <= p2_out;
         p6s <= p6_out;
         strb <= strb + 1;
      end
      if (ale) begin
         alen <= alen + 1;
         alo <= p0_out;
      end
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
      @(posedge clk);
      #1 {sfr_wr, sfr_rd} = 2'b00;
      v = sfr_rdata;
   endtask
   // one data access, its answer and the pin activity it caused
   task automatic acc(input emb_row_t r);
      int n;
      logic ext;
      n = 0;
      ext = r.f[3] & r.adr[15];
      sfr(1'b1, 8'hD9, r.ctrl);
      {ext_en, gen_en, req_we, req_ri, nonmux, lag} = {r.f, r.ctrl[7], r.lag};
      {strb, alen, bad, busy, req} = {32'd0, 32'd0, 1'b0, 1'b1, 1'b1};
      req_addr = r.f[0] ? 16'h0000 : r.adr;
      {req_ri_low, req_wdata} = {r.adr[7:0], r.d};
      do begin
         @(posedge clk);
         #1 n++;
      end while (ack !== 1'b1 && n < 40);
      if (!r.f[1]) chk(16'(rdata), 16'(r.d));
      chk(16'(n), ext ? 16'(r.ctrl[3:0]) + 16'h3 : 16'h2);
      @(posedge clk);
      #1 {req, busy} = 2'b00;
      chk(16'(strb), ext ? 16'(r.ctrl[3:0]) + 16'h1 : 16'h0);
      chk(16'(alen), 16'(ext & !r.ctrl[7] & !(r.ctrl[6] & r.f[2])));
      if (ext && r.ctrl[6] && r.f[2])
         chk(16'(p2s), {8'h00, ~(4'h1 << r.adr[13:12]), r.adr[11:8]});
      else if (ext) chk(16'(p2s), {9'h000, r.adr[14:8]});
      if (ext && r.ctrl[7]) chk(16'(p6s), 16'(r.adr[7:0]));
      if (alen != 0) chk(16'(alo), 16'(r.adr[7:0]));
      chk(16'(bad), 16'h0);
   endtask
   task wrap_up;
      if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ************************************************************
   // sequence and watchdog
   // ************************************************************
   initial begin
      #40000 errors++;
      wrap_up();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      sfr(1'b0, 8'hD9, 8'h00);
      chk(16'(v), 16'h0000);
      sfr(1'b1, 8'hF1, 8'h90);
      for (int i = 0; i < 20; i++) acc(rows[i]);
      sfr(1'b1, 8'hD9, 8'hFF);
      sfr(1'b0, 8'hD9, 8'h00);
      chk(16'(v), 16'h00CF);
      sfr(1'b0, 8'h55, 8'h00);
      chk(16'(v), 16'h0000);
      // code sits in the RAM and we run from inside it before switching to above it
      code_ram = 1'b1;
      fetch_addr = 16'h0123;
      @(posedge clk);
      #1 chk(16'(fetch_from_ram), 16'h1);
      chk(16'(fetch_data), 16'h00C3);
      fetch_addr = 16'h1123;
      #1 chk(16'(fetch_from_ram), 16'h0);
      // second reset in mid-run returns the pins to idle and the page register to zero
      @(posedge clk);
      #1 rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_b = 1'b1;
      chk(16'({ack, req_ready, p0_oe, rd_n, wr_n, ale}), 16'h0016);
      sfr(1'b0, 8'hF1, 8'h00);
      chk(16'(v), 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: bench/emb_mem_model.sv */
/*
 * emb_mem_model: byte-wide external memory on the far side of the bus.
 * Assumes the device drives its pins from clk and that the bench tells
 * it the bus arrangement and how slow the part answers reads.
 */
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
   // clock
   input wire logic clk,
   // bus pins of the device
   input wire logic [7:0] p0_out,
   input wire logic p0_oe,
   input wire logic [7:0] p2_out,
   input wire logic [7:0] p6_out,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ale,
   output logic [7:0] p0_in,
   // set up by the bench
   input wire logic nonmux,
   input wire logic [3:0] resp_lag
);
   // ************************************************************
   // storage and address decode
   // ************************************************************
   logic [7:0] mem [0:32767];
   logic [7:0] lo_lat = 8'h00;
   logic [7:0] last = 8'h00;
   logic [3:0] low_cnt = 4'h0;
   logic [14:0] adr;
   // line 15 is not wired to the part, so only 32KB are decoded
   assign adr = {p2_out[6:0], nonmux ? p6_out : lo_lat};
   // external transparent latch, modelled as capture while ale is high
   always @(posedge clk) if (ale) lo_lat <= p0_out;
   // counts strobe cycles so a slow part can hold back its data
   always @(posedge clk) low_cnt <= rd_n ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'hF};
   // a write lands only while the device really drives the data lines
   always @(posedge clk) if (!wr_n && p0_oe) mem[adr] <= p0_out;
   // released lines toggle every cycle so stale data never looks valid
   always @(posedge clk) last <= p0_in;
   assign p0_in = (!rd_n && low_cnt >= resp_lag) ? mem[adr] : ~last;
endmodule
`default_nettype wire

/* File: include/emb_pkg.sv */
/*
 * emb_pkg: shared constants and types of the external memory bus
 * interface. Assumes nothing about the surroundings.
 */
`default_nettype none
package emb_pkg;
   // ************************************************************
   // special function register offsets and reset values
   // ************************************************************
   localparam logic [7:0] ADDR_BUS_CONTROL = 8'hD9;
   localparam logic [7:0] ADDR_PAGE = 8'hF1;
   localparam logic [7:0] RST_BUS_CONTROL = 8'h00;
   localparam logic [7:0] RST_PAGE = 8'h00;
   // ************************************************************
   // field positions of the bus control register
   // ************************************************************
   localparam int BIT_NONMUX = 7;
   localparam int BIT_CS_MODE = 6;
   localparam int STRETCH_HI = 3;
   localparam int STRETCH_LO = 0;
   localparam logic [7:0] CTRL_USED_MASK = 8'hCF;
   // ************************************************************
   // memory map
   // ************************************************************
   localparam logic [3:0] RAM_TOP_NIBBLE = 4'h0;
   localparam int RAM_DEPTH = 4096;
   localparam logic [3:0] CS_IDLE = 4'hF;
   localparam logic [7:0] PORT_IDLE = 8'h00;
   // ************************************************************
   // access sequencer states
   // ************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_STRB = 4'h4,
      ST_DONE = 4'h8
   } emb_state_t;
endpackage
`default_nettype wire

/* File: rtl/emb_ext_bus.sv */
/*
 * emb_ext_bus: external data memory bus interface with on-chip 4KB
 * RAM, page register, chip-select decode and stretch cycles.
 * Assumes the core holds a data request until ack, reaches the two
 * registers over the special function register port, and supplies
 * the bus enable bits of registers kept elsewhere as plain levels.
 */
// Overview of operation
// - control bit 7 set selects non-multiplexed bus, clear selects multiplexed.
// - non-multiplexed: data on port 0, low address port 6, high port 2.
// - pointer-register moves take upper address byte from page register.
// - chip-select mode needs control bit 6 and general bus enable both set.
// - chip-select mode: port 2 bits 7..4 selects, bits 3..0 address 11..8.
// - chip-select mode: low address on port 6, port 0 data if non-multiplexed.
// - chip-select mode keeps read/write strobes, holds latch enable low.
// - select line chosen from address bits 13..12; bits 15..14 ignored.
// - 8000h-BFFFh map in 4KB steps to selects 4..7, repeat above, none below.
// - external cycles only for 8000h-FFFFh and only while bus enabled.
// - address line 15 stays low during external accesses.
// - data moves to 0000h-0FFFh use the on-chip 4KB RAM.
// - control bits 3..0 insert 0 to 15 stretch cycles per access.
// - with chip-select bit clear, all upper lines carry address.
// - code-from-RAM bit set: fetches in 0000h-0FFFh come from on-chip RAM.
// - multiplexed: port 0 shares low address and data, latch enable pulses unless in chip-select mode.
// - after reset accesses are multiplexed until software changes mode.
`timescale 1ns/1ps
`default_nettype none
module emb_ext_bus (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // special function register port
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // bits of registers held elsewhere
   input wire logic external_bus_enable_bit,
   input wire logic bus_general_enable_bit,
   input wire logic code_from_ram_bit,
   // core data request
   input wire logic req,
   input wire logic req_we,
   input wire logic req_ri,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_ri_low,
   input wire logic [7:0] req_wdata,
   output logic req_ready,
   output logic ack,
   output logic [7:0] rdata,
   // core code fetch
   input wire logic [15:0] fetch_addr,
   output logic fetch_from_ram,
   output logic [7:0] fetch_data,
   // external pins
   input wire logic [7:0] p0_in,
   output logic [7:0] p0_out,
   output logic p0_oe,
   output logic [7:0] p2_out,
   output logic [7:0] p6_out,
   output logic rd_n,
   output logic wr_n,
   output logic ale
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] ctrl;
   logic [7:0] page;
   logic cs_mode;
   logic [7:0] p0_meta;
   logic [7:0] p0_sync;

   // chip-select mode needs both enables
   assign cs_mode = ctrl[emb_pkg::BIT_CS_MODE] & bus_general_enable_bit;

   // register writes; reset leaves the bus multiplexed
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= emb_pkg::RST_BUS_CONTROL;
         page <= emb_pkg::RST_PAGE;
      end else if (sfr_wr) begin
         if (sfr_addr == emb_pkg::ADDR_BUS_CONTROL) begin
            ctrl <= sfr_wdata & emb_pkg::CTRL_USED_MASK;
         end
         if (sfr_addr == emb_pkg::ADDR_PAGE) begin
            page <= sfr_wdata;
         end
      end
   end

   // register reads, registered; other offsets answer zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            emb_pkg::ADDR_BUS_CONTROL: sfr_rdata <= ctrl;
            emb_pkg::ADDR_PAGE: sfr_rdata <= page;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // pin synchroniser for read data; costs two clocks of stretch
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         p0_meta <= 8'h00;
         p0_sync <= 8'h00;
      end else begin
         p0_meta <= p0_in;
         p0_sync <= p0_meta;
      end
   end

   // ************************************************************
   // address decode
   // ************************************************************
   logic [15:0] eff_addr;
   logic in_ram;
   logic ext_ok;
   logic take;
   logic [7:0] ram_q;
   emb_pkg::emb_state_t state;

   // pointer-register moves are paged
   assign eff_addr = req_ri ? {page, req_ri_low} : req_addr;
   assign in_ram = eff_addr[15:12] == emb_pkg::RAM_TOP_NIBBLE;
   assign ext_ok = eff_addr[15] & external_bus_enable_bit;
   assign req_ready = state == emb_pkg::ST_IDLE;
   assign take = req & req_ready;

   // ************************************************************
   // access sequencer
   // ************************************************************
   logic [15:0] lat_addr;
   logic lat_we;
   logic lat_ext;
   logic lat_ram;
   logic lat_cs;
   logic lat_nonmux;
   logic [3:0] lat_stretch;
   logic [3:0] cnt;
   logic [3:0] cs_lines;
   logic [7:0] p2_reg;

   // active-low select from bits 13..12; bits 15..14 play no part
   assign cs_lines = ~(4'h1 << lat_addr[13:12]);
   // selects stay high in ST_IDLE after an access taken in chip-select mode so no peripheral sees a stray access
   assign p2_out = (lat_cs && state == emb_pkg::ST_IDLE) ?
                   {emb_pkg::CS_IDLE, p2_reg[3:0]} : p2_reg;

   // one process owns the pins so address, data and selects move together
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= emb_pkg::ST_IDLE;
         lat_addr <= 16'h0000;
         lat_we <= 1'b0;
         lat_ext <= 1'b0;
         lat_ram <= 1'b0;
         lat_cs <= 1'b0;
         lat_nonmux <= 1'b0;
         lat_stretch <= 4'h0;
         cnt <= 4'h0;
         rdata <= 8'h00;
         p0_out <= emb_pkg::PORT_IDLE;
         p0_oe <= 1'b0;
         p2_reg <= emb_pkg::PORT_IDLE;
         p6_out <= emb_pkg::PORT_IDLE;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         ale <= 1'b0;
      end else begin
         case (state)
            emb_pkg::ST_IDLE: begin
               if (take) begin
                  lat_addr <= eff_addr;
                  lat_we <= req_we;
                  lat_ram <= in_ram;
                  lat_ext <= ext_ok;
                  lat_cs <= cs_mode;
                  lat_nonmux <= ctrl[emb_pkg::BIT_NONMUX];
                  lat_stretch <= ctrl[emb_pkg::STRETCH_HI:emb_pkg::STRETCH_LO];
                  state <= emb_pkg::ST_ADDR;
                  if (ext_ok) begin
                     // mux mode latches low address; chip-select holds it low
                     ale <= ~ctrl[emb_pkg::BIT_NONMUX] & ~cs_mode;
                     p0_oe <= ~ctrl[emb_pkg::BIT_NONMUX];
                     p0_out <= eff_addr[7:0];
                     p6_out <= (ctrl[emb_pkg::BIT_NONMUX] | cs_mode) ?
                               eff_addr[7:0] : emb_pkg::PORT_IDLE;
                     if (cs_mode) begin
                        p2_reg <= {~(4'h1 << eff_addr[13:12]), eff_addr[11:8]};
                     end else begin
                        p2_reg <= {1'b0, eff_addr[14:8]};
                     end
                  end
               end
            end
            emb_pkg::ST_ADDR: begin
               if (lat_ext) begin
                  ale <= 1'b0;
                  rd_n <= lat_we;
                  wr_n <= ~lat_we;
                  p0_out <= lat_we ? req_wdata : p0_out;
                  p0_oe <= lat_we;
                  cnt <= lat_stretch;
                  state <= emb_pkg::ST_STRB;
               end else begin
                  // unmapped holes read back zero
                  rdata <= lat_ram ? ram_q : 8'h00;
                  state <= emb_pkg::ST_DONE;
               end
            end
            emb_pkg::ST_STRB: begin
               // strobe low for one clock plus one per stretch count
               if (cnt == 4'h0) begin
                  rdata <= lat_we ? rdata : p0_sync;
                  rd_n <= 1'b1;
                  wr_n <= 1'b1;
                  state <= emb_pkg::ST_DONE;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            emb_pkg::ST_DONE: begin
               p0_oe <= 1'b0;
               state <= emb_pkg::ST_IDLE;
            end
            default: begin
               state <= emb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign ack = state == emb_pkg::ST_DONE;

   // ************************************************************
   // on-chip RAM and code fetch
   // ************************************************************
   assign fetch_from_ram = code_from_ram_bit &
                           (fetch_addr[15:12] == emb_pkg::RAM_TOP_NIBBLE);

   emb_ram4k #(
      .DEPTH(emb_pkg::RAM_DEPTH),
      .AW(12)
   ) u_ram (
      .clk(clk),
      .d_en(take & in_ram),
      .d_we(req_we),
      .d_addr(eff_addr[11:0]),
      .d_wdata(req_wdata),
      .d_q(ram_q),
      .f_en(fetch_from_ram),
      .f_addr(fetch_addr[11:0]),
      .f_q(fetch_data)
   );

   // ************************************************************
   // checks
   // ************************************************************
   logic strobe;
   logic [4:0] strb_len;
   assign strobe = ~rd_n | ~wr_n;

   // strobe length counter for the stretch check
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strb_len <= 5'h00;
      end else begin
         strb_len <= strobe ? strb_len + 5'h01 : 5'h00;
      end
   end

   property p_mode_ale;
      @(posedge clk) disable iff (!rst_b)
      (take && ext_ok) |=> (ale == !(lat_nonmux || lat_cs));
   endproperty
   a_mode_ale: assert property (p_mode_ale) else $error("latch enable wrong for mode");

   property p_page;
      @(posedge clk) disable iff (!rst_b)
      (take && req_ri) |=> (lat_addr == {$past(page), $past(req_ri_low)});
   endproperty
   a_page: assert property (p_page) else $error("paged address wrong");

   property p_cs_ale;
      @(posedge clk) disable iff (!rst_b)
      (lat_cs && state != emb_pkg::ST_IDLE) |-> !ale;
   endproperty
   a_cs_ale: assert property (p_cs_ale) else $error("latch enable in select mode");

   property p_cs_decode;
      @(posedge clk) disable iff (!rst_b)
      (strobe && lat_cs) |-> (p2_out[7:4] == cs_lines && p6_out == lat_addr[7:0]);
   endproperty
   a_cs_decode: assert property (p_cs_decode) else $error("select decode wrong");

   property p_a15_low;
      @(posedge clk) disable iff (!rst_b)
      (strobe && !lat_cs) |-> !p2_out[7] && p2_out[6:0] == lat_addr[14:8];
   endproperty
   a_a15_low: assert property (p_a15_low) else $error("upper address wrong");

   property p_no_ext_low;
      @(posedge clk) disable iff (!rst_b)
      (take && !eff_addr[15]) |=> !lat_ext ##1 !strobe;
   endproperty
   a_no_ext_low: assert property (p_no_ext_low) else $error("bus cycle below window");

   property p_ram_ack;
      @(posedge clk) disable iff (!rst_b)
      (take && in_ram) |-> ##2 ack;
   endproperty
   a_ram_ack: assert property (p_ram_ack) else $error("RAM access not answered");

   property p_stretch;
      @(posedge clk) disable iff (!rst_b)
      $fell(strobe) |-> (strb_len == {1'b0, lat_stretch} + 5'h01);
   endproperty
   a_stretch: assert property (p_stretch) else $error("strobe length wrong");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      (strobe && $past(strobe)) |-> $stable(p2_out) && $stable(p6_out) && $stable(p0_out);
   endproperty
   a_hold: assert property (p_hold) else $error("lines moved during strobe");

   property p_fetch;
      @(posedge clk) disable iff (!rst_b)
      (!code_from_ram_bit || fetch_addr[15:12] != 4'h0) |-> !fetch_from_ram;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch from RAM wrongly");
endmodule
`default_nettype wire

/* File: rtl/emb_ram4k.sv */
/*
 * emb_ram4k: on-chip data/code RAM, one read-write port for data
 * moves and one read port for instruction fetch.
 * Assumes both ports run on clk; reads return one edge later.
 */
`timescale 1ns/1ps
`default_nettype none
module emb_ram4k #(
   parameter int DEPTH = emb_pkg::RAM_DEPTH,
   parameter int AW = 12
) (
   // clock
   input wire logic clk,
   // data port
   input wire logic d_en,
   input wire logic d_we,
   input wire logic [AW-1:0] d_addr,
   input wire logic [7:0] d_wdata,
   output logic [7:0] d_q,
   // fetch port
   input wire logic f_en,
   input wire logic [AW-1:0] f_addr,
   output logic [7:0] f_q
);
   logic [7:0] mem [DEPTH];

   // data port: read first, read data registered
   always_ff @(posedge clk) begin
      if (d_en) begin
         if (d_we) begin
            mem[d_addr] <= d_wdata;
         end
         d_q <= mem[d_addr];
      end
   end

   // fetch port: read only, so a code write must go through data moves
   always_ff @(posedge clk) begin
      if (f_en) begin
         f_q <= mem[f_addr];
      end
   end
endmodule
`default_nettype wire
